// ==== design/cps_defs.svh ====
// Timing and threshold constants for the compressor protection supervisor
`ifndef CPS_DEFS_SVH
`define CPS_DEFS_SVH

// ----------------------------------------------------------------
// Timebase
// ----------------------------------------------------------------
`define CPS_SEC_NS 1000000000
`define CPS_CLK_NS 4
`define CPS_MIN_S 60

// ----------------------------------------------------------------
// Delays, in minutes or seconds as named
// ----------------------------------------------------------------
`define CPS_RESTART_MIN 3
`define CPS_DC_LATE_MIN 1
`define CPS_DC_EARLY_MIN 2
`define CPS_DC_EARLY_S 30
`define CPS_SOFT_OK_S 5
`define CPS_COOL_INIT_MIN 30
`define CPS_LEAK_RUN_MIN 5
`define CPS_WIN_MIN 20
`define CPS_LOWF_MIN 240
`define CPS_FORCE_MIN 2
`define CPS_OUTAIR_MIN 1

// ----------------------------------------------------------------
// Repetition limits and window slots
// ----------------------------------------------------------------
`define CPS_DC_EARLY_LIM 7
`define CPS_PSM_LIM 4
`define CPS_DIS_LIM 4
`define CPS_LEAK_LIM 2
`define CPS_W_PSM 0
`define CPS_W_DIS 1
`define CPS_W_LEAK 2
`define CPS_NWIN 3

`endif

// ==== design/cps_pkg.sv ====
// Types shared by the compressor protection supervisor
package cps_pkg;

    typedef enum logic [2:0] {
        CPS_ST_OFF = 3'h0,
        CPS_ST_RUN = 3'h1,
        CPS_ST_HOLD = 3'h2,
        CPS_ST_COOLWAIT = 3'h3,
        CPS_ST_LOCK = 3'h4
    } cps_state_e;

    typedef enum logic [2:0] {
        CPS_FLT_NONE = 3'h0,
        CPS_FLT_LEAK = 3'h1,
        CPS_FLT_PSM = 3'h2,
        CPS_FLT_DIS = 3'h3,
        CPS_FLT_DC = 3'h4
    } cps_fault_e;

    // Comparator flags and mode levels from outside
    typedef struct packed {
        logic run_req;
        logic cool_mode;
        logic heat_mode;
        logic cur_soft_init;
        logic cur_soft_norm;
        logic cur_hard;
        logic psm_hot;
        logic psm_cool;
        logic dc_over;
        logic dis_hot;
        logic cur_leak_band;
        logic leak_dt_cool;
        logic leak_dt_heat;
        logic freq_lt24;
        logic lf_in_c;
        logic lf_out_c;
        logic lf_hx_c;
        logic lf_in_h;
        logic lf_out_h;
        logic lf_hx_h;
    } cps_sens_s;

    typedef struct packed {
        logic comp_run;
        logic freq_down;
        logic freq_up_ok;
        logic freq_lower;
        logic force_23hz;
        logic outair_reg_en;
        logic relay_cut;
        logic op_stop;
        logic timer_blink;
        cps_fault_e fault_code;
    } cps_ctrl_s;

endpackage : cps_pkg

// ==== design/cps_top.sv ====
// Compressor protection supervisor: trips, hold-offs, limits, faults
//
// Summary of operation
// [RULE_01] After any stop but a repeat DC trip the compressor stays off three minutes.
// [RULE_02] No hold-off follows power-on reset.
// [RULE_03] Current above soft limit requests a frequency step down.
// [RULE_04] Five seconds at or below soft limit allows stepping up.
// [RULE_05] Current above hard limit stops compressor, three minute hold.
// [RULE_06] First thirty cooling minutes use the initial soft-limit set.
// [RULE_07] Power stage module at 100 C stops compressor at once.
// [RULE_08] Restart three minutes after module cools to 95 C.
// [RULE_09] Four module overheat stops in twenty minutes latch fault.
// [RULE_10] DC peak trip stops compressor; first restart after three min.
// [RULE_11] Repeat DC trip after thirty seconds running: one minute.
// [RULE_12] Repeat DC trip within thirty seconds: two minutes.
// [RULE_13] Seven early DC trips cut relays, latch fault, blink.
// [RULE_14] Discharge over 103 C stops; four in twenty minutes latch.
// [RULE_15] Leak needs five minutes running with current in leak band.
// [RULE_16] Cooling or dry also needs intake minus pipe below 4 C.
// [RULE_17] Heating also needs pipe minus intake under 5 C.
// [RULE_18] Leak stops with three minute hold; two in twenty latch.
// [RULE_19] Below 24 Hz for 240 minutes forces 23 Hz two minutes.
// [RULE_20] Cooling: all three band flags request lower frequency.
// [RULE_21] Heating: all three band flags request lower frequency.
// [RULE_22] Outdoor-air regulation in cooling starts one minute after start.
// [RULE_23] Window counters age out old events; reset clears counters.
// [RULE_24] Thresholds and limits arrive as flags, not computed here.
`timescale 1ns/1ps
`default_nettype none
`include "cps_defs.svh"

module cps_top #(
    parameter int unsigned SEC_CYCLES = `CPS_SEC_NS / `CPS_CLK_NS
) (
    input wire logic CLK,
    input wire logic SYS_RST,
    input wire cps_pkg::cps_sens_s SENS,
    output var cps_pkg::cps_ctrl_s CTRL
);
    import cps_pkg::*;

    localparam int SW = $bits(cps_sens_s);
    localparam logic [2:0][2:0] WIN_LIM = {
        3'(`CPS_LEAK_LIM), 3'(`CPS_DIS_LIM), 3'(`CPS_PSM_LIM)
    };

    typedef struct packed {
        cps_state_e st;
        logic [27:0] tb_cyc;
        logic [5:0] tb_sec;
        logic [7:0] hold_s;
        logic [5:0] run_s;
        logic [2:0] soft_ok_s;
        logic [4:0] cool_m;
        logic [8:0] leak_s;
        logic [7:0] lowf_m;
        logic [6:0] force_s;
        logic dc_seen;
        logic [2:0] dc_early;
        logic [2:0][2:0] win_n;
        logic [2:0][10:0] win_s;
        cps_fault_e fault;
        cps_ctrl_s o;
    } cps_core_s;

    // ----------------------------------------------------------------
    // Input synchronisers
    // ----------------------------------------------------------------
    logic [SW-1:0] raw;
    logic [SW-1:0] filt;
    assign raw = SENS;

    for (genvar i = 0; i < SW; i++) begin : g_sync
        logic [2:0] sh_q;
        logic f_q;
        always_ff @(posedge CLK) begin
            if (SYS_RST) begin
                sh_q <= 3'h0;
                f_q <= 1'b0;
            end else begin
                sh_q <= {sh_q[1:0], raw[i]};
                // Glitch filter: take a level only once stages agree
                if (sh_q[1] == sh_q[2]) begin
                    f_q <= sh_q[2];
                end
            end
        end
        assign filt[i] = f_q;
    end

    // ----------------------------------------------------------------
    // Supervisor core
    // ----------------------------------------------------------------
    cps_core_s q;
    cps_core_s n;
    cps_sens_s s;
    logic sec_tick, min_tick, run, cool_init, soft_over, leak_cond;
    logic t_hard, t_psm, t_dc, t_dis, t_leak, trip, dc_early_trip;
    logic [7:0] dc_delay;
    logic [2:0] ev, win_hit, aged;
    cps_fault_e new_fault;

    assign s = cps_sens_s'(filt);

    always_comb begin
        n = q;
        aged = 3'h0;
        run = (q.st == CPS_ST_RUN);
        sec_tick = (q.tb_cyc == 28'(SEC_CYCLES - 1));
        min_tick = sec_tick && (q.tb_sec == 6'(`CPS_MIN_S - 1));
        n.tb_cyc = sec_tick ? 28'h0 : q.tb_cyc + 28'h1;
        if (sec_tick) begin
            n.tb_sec = min_tick ? 6'h0 : q.tb_sec + 6'h1;
        end

        cool_init = s.cool_mode &&
            (q.cool_m < 5'(`CPS_COOL_INIT_MIN)); // RULE_06
        soft_over = cool_init ? s.cur_soft_init
                              : s.cur_soft_norm; // RULE_24

        leak_cond = s.cur_leak_band && // RULE_15
            ((s.cool_mode && s.leak_dt_cool) || // RULE_16
             (s.heat_mode && s.leak_dt_heat)); // RULE_17

        t_hard = run && s.cur_hard; // RULE_05
        t_psm = run && s.psm_hot; // RULE_07
        t_dc = run && s.dc_over; // RULE_10
        t_dis = run && s.dis_hot; // RULE_14
        t_leak = run && (q.leak_s >=
            9'(`CPS_LEAK_RUN_MIN * `CPS_MIN_S)); // RULE_15
        trip = t_hard || t_psm || t_dc || t_dis || t_leak;

        // First DC trip waits the full restart time
        dc_early_trip = t_dc && q.dc_seen &&
            (q.run_s <= 6'(`CPS_DC_EARLY_S));
        if (!q.dc_seen) begin
            dc_delay = 8'(`CPS_RESTART_MIN * `CPS_MIN_S); // RULE_10
        end else if (dc_early_trip) begin
            dc_delay = 8'(`CPS_DC_EARLY_MIN * `CPS_MIN_S); // RULE_12
        end else begin
            dc_delay = 8'(`CPS_DC_LATE_MIN * `CPS_MIN_S); // RULE_11
        end

        if (t_dc) begin
            n.dc_seen = 1'b1;
            n.dc_early = dc_early_trip ? q.dc_early + 3'h1 : 3'h0;
        end

        // Windowed repeat counters; a new event beats aging
        ev[`CPS_W_PSM] = t_psm;
        ev[`CPS_W_DIS] = t_dis;
        ev[`CPS_W_LEAK] = t_leak;
        for (int i = 0; i < `CPS_NWIN; i++) begin
            if (q.win_n[i] != 3'h0 && sec_tick) begin
                n.win_s[i] = q.win_s[i] + 11'h1;
                if (q.win_s[i] >=
                    11'(`CPS_WIN_MIN * `CPS_MIN_S - 1)) begin
                    n.win_n[i] = 3'h0; // RULE_23
                    aged[i] = 1'b1;
                end
            end
            if (ev[i]) begin
                if (q.win_n[i] == 3'h0 || aged[i]) begin
                    n.win_s[i] = 11'h0;
                end
                n.win_n[i] = aged[i] ? 3'h1 : q.win_n[i] + 3'h1;
            end
            win_hit[i] = ev[i] && (n.win_n[i] == WIN_LIM[i]);
        end

        if (t_dc && dc_early_trip &&
            q.dc_early == 3'(`CPS_DC_EARLY_LIM - 1)) begin
            new_fault = CPS_FLT_DC; // RULE_13
        end else if (win_hit[`CPS_W_PSM]) begin
            new_fault = CPS_FLT_PSM; // RULE_09
        end else if (win_hit[`CPS_W_DIS]) begin
            new_fault = CPS_FLT_DIS; // RULE_14
        end else if (win_hit[`CPS_W_LEAK]) begin
            new_fault = CPS_FLT_LEAK; // RULE_18
        end else begin
            new_fault = CPS_FLT_NONE;
        end
        if (q.fault == CPS_FLT_NONE) begin
            n.fault = new_fault;
        end

        case (q.st)
            CPS_ST_OFF: begin
                // Power-on lands here with no pending delay
                if (s.run_req) begin
                    n.st = CPS_ST_RUN; // RULE_02
                end
            end
            CPS_ST_RUN: begin
                if (n.fault != CPS_FLT_NONE) begin
                    n.st = CPS_ST_LOCK;
                end else if (t_psm) begin
                    n.st = CPS_ST_COOLWAIT; // RULE_07
                end else if (trip) begin
                    n.st = CPS_ST_HOLD; // RULE_05
                    n.hold_s = (t_dc && !(t_hard || t_dis || t_leak))
                        ? dc_delay
                        : 8'(`CPS_RESTART_MIN * `CPS_MIN_S); // RULE_18
                end else if (!s.run_req) begin
                    n.st = CPS_ST_HOLD;
                    n.hold_s = 8'(`CPS_RESTART_MIN * `CPS_MIN_S); // RULE_01
                end
            end
            CPS_ST_HOLD: begin
                // Run requests are ignored until the delay expires
                if (q.hold_s == 8'h0) begin
                    n.st = CPS_ST_OFF; // RULE_01
                end else if (sec_tick) begin
                    n.hold_s = q.hold_s - 8'h1;
                end
            end
            CPS_ST_COOLWAIT: begin
                if (s.psm_cool) begin
                    n.st = CPS_ST_HOLD; // RULE_08
                    n.hold_s = 8'(`CPS_RESTART_MIN * `CPS_MIN_S);
                end
            end
            CPS_ST_LOCK: begin
                // Only reset leaves a latched fault
                n.st = CPS_ST_LOCK;
            end
            default: begin
                n.st = CPS_ST_OFF;
            end
        endcase

        if (!run) begin
            n.run_s = 6'h0;
        end else if (sec_tick && q.run_s != 6'h3F) begin
            n.run_s = q.run_s + 6'h1;
        end

        if (!run || soft_over) begin
            n.soft_ok_s = 3'h0;
        end else if (sec_tick &&
                     q.soft_ok_s < 3'(`CPS_SOFT_OK_S)) begin
            n.soft_ok_s = q.soft_ok_s + 3'h1; // RULE_04
        end

        if (!s.cool_mode) begin
            n.cool_m = 5'h0;
        end else if (min_tick &&
                     q.cool_m < 5'(`CPS_COOL_INIT_MIN)) begin
            n.cool_m = q.cool_m + 5'h1; // RULE_06
        end

        // Leak timer only runs while the whole condition holds
        if (!run || !leak_cond) begin
            n.leak_s = 9'h0;
        end else if (sec_tick && !t_leak) begin
            n.leak_s = q.leak_s + 9'h1; // RULE_15
        end

        if (!run) begin
            n.force_s = 7'h0;
            n.lowf_m = 8'h0;
        end else if (q.force_s != 7'h0) begin
            n.lowf_m = 8'h0;
            if (sec_tick) begin
                n.force_s = q.force_s - 7'h1;
            end
        end else if (!s.freq_lt24) begin
            n.lowf_m = 8'h0;
        end else if (q.lowf_m == 8'(`CPS_LOWF_MIN)) begin
            n.force_s = 7'(`CPS_FORCE_MIN * `CPS_MIN_S); // RULE_19
            n.lowf_m = 8'h0;
        end else if (min_tick) begin
            n.lowf_m = q.lowf_m + 8'h1; // RULE_19
        end

        n.o.comp_run = (n.st == CPS_ST_RUN);
        n.o.freq_down = n.o.comp_run && soft_over; // RULE_03
        n.o.freq_up_ok = n.o.comp_run &&
            (n.soft_ok_s == 3'(`CPS_SOFT_OK_S)); // RULE_04
        n.o.freq_lower = n.o.comp_run &&
            ((s.cool_mode && s.lf_in_c && s.lf_out_c &&
              s.lf_hx_c) || // RULE_20
             (s.heat_mode && s.lf_in_h && s.lf_out_h &&
              s.lf_hx_h)); // RULE_21
        n.o.force_23hz = n.o.comp_run && (n.force_s != 7'h0);
        n.o.outair_reg_en = n.o.comp_run && s.cool_mode &&
            (n.run_s >= 6'(`CPS_OUTAIR_MIN * `CPS_MIN_S)); // RULE_22
        n.o.relay_cut = (n.fault == CPS_FLT_DC); // RULE_13
        n.o.op_stop = (n.fault != CPS_FLT_NONE); // RULE_18
        n.o.timer_blink = (n.fault != CPS_FLT_NONE); // RULE_09
        n.o.fault_code = n.fault;
    end

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            q <= '0; // RULE_23
        end else begin
            q <= n;
        end
    end

    assign CTRL = q.o;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge CLK); endclocking
    default disable iff (SYS_RST);

    a_stop_holdoff: assert property ( // RULE_01
        (run && !s.run_req && !trip && n.fault == CPS_FLT_NONE)
        |=> (q.st == CPS_ST_HOLD) &&
            (q.hold_s == 8'(`CPS_RESTART_MIN * `CPS_MIN_S))
            ##1 !CTRL.comp_run [*8])
        else $error("stop did not load restart hold-off");
    a_por_clean: assert property ( // RULE_02
        $fell(SYS_RST) |-> q.hold_s == 8'h0 && q.st == CPS_ST_OFF)
        else $error("hold-off present after reset");
    a_soft_down: assert property ( // RULE_03
        (run && soft_over && !trip && n.fault == CPS_FLT_NONE &&
         s.run_req) |=> CTRL.freq_down)
        else $error("soft limit did not request step down");
    a_up_after_5s: assert property ( // RULE_04
        $rose(CTRL.freq_up_ok) |->
            $past(q.soft_ok_s) >= 3'(`CPS_SOFT_OK_S - 1))
        else $error("step up allowed before five seconds");
    a_hard_stop: assert property ( // RULE_05
        (t_hard && !t_psm && n.fault == CPS_FLT_NONE)
        |=> !CTRL.comp_run &&
            q.hold_s == 8'(`CPS_RESTART_MIN * `CPS_MIN_S))
        else $error("hard current did not stop compressor");
    a_psm_stop: assert property ( // RULE_07
        t_psm |=> !CTRL.comp_run)
        else $error("module overheat did not stop compressor");
    a_psm_wait: assert property ( // RULE_08
        (q.st == CPS_ST_COOLWAIT && !s.psm_cool &&
         q.fault == CPS_FLT_NONE) |=> q.st == CPS_ST_COOLWAIT)
        else $error("restart before module cooled");
    a_dc_late: assert property ( // RULE_11
        (t_dc && q.dc_seen && q.run_s > 6'(`CPS_DC_EARLY_S) && !t_hard &&
         !t_dis && !t_leak && !t_psm && n.fault == CPS_FLT_NONE)
        |=> q.hold_s == 8'(`CPS_DC_LATE_MIN * `CPS_MIN_S))
        else $error("late DC trip delay is not one minute");
    a_dc_early: assert property ( // RULE_12
        (dc_early_trip && !t_hard && !t_dis && !t_leak && !t_psm &&
         n.fault == CPS_FLT_NONE)
        |=> q.hold_s == 8'(`CPS_DC_EARLY_MIN * `CPS_MIN_S))
        else $error("early DC trip delay is not two minutes");
    a_dc_fault: assert property ( // RULE_13
        (q.fault == CPS_FLT_DC) |-> CTRL.relay_cut && CTRL.timer_blink
            && !CTRL.comp_run)
        else $error("DC fault without relay cut");

    c_restart: cover property (
        q.st == CPS_ST_HOLD ##1 q.st == CPS_ST_OFF ##1 CTRL.comp_run);
    c_dc_lock: cover property (q.fault == CPS_FLT_DC);
    c_leak_lock: cover property (q.fault == CPS_FLT_LEAK);
    c_force: cover property ($rose(CTRL.force_23hz));

endmodule : cps_top

`default_nettype wire

// ==== dv/cps_plant_model.sv ====
// Plant model: compressor drive and the sensors seen by the supervisor
`timescale 1ns/1ps
`default_nettype none

module cps_plant_model (
    input wire logic clk,
    input wire cps_pkg::cps_sens_s want,
    input wire logic running,
    output var cps_pkg::cps_sens_s sens
);
    import cps_pkg::*;

    cps_sens_s sens_d;

    // ------------------------------------------------------------
    // Current-derived flags
    // ------------------------------------------------------------
    // A stopped motor draws no current, so no current flag can stay up
    always_comb begin
        sens_d = want;
        if (!running) begin
            sens_d.cur_soft_init = 1'b0;
            sens_d.cur_soft_norm = 1'b0;
            sens_d.cur_hard = 1'b0;
            sens_d.dc_over = 1'b0;
            sens_d.cur_leak_band = 1'b0;
            sens_d.freq_lt24 = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        sens <= sens_d;
    end

endmodule : cps_plant_model

`default_nettype wire

// ==== dv/tb_cps_top.sv ====
// Self-checking bench for the compressor protection supervisor
`timescale 1ns/1ps
`default_nettype none

module tb_cps_top;
    import cps_pkg::*;

    // ------------------------------------------------------------
    // Setup
    // ------------------------------------------------------------
    // Ten cycles per second keeps three-minute holds short
    localparam int SC = 10;
    localparam int RUN_B = 19, COOL_B = 18, HEAT_B = 17, INIT_B = 16;
    localparam int NORM_B = 15, HARD_B = 14, HOT_B = 13, COOLED_B = 12;
    localparam int DC_B = 11, DIS_B = 10, DTC_B = 8, DTH_B = 7;

    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    cps_sens_s want = '0;
    cps_sens_s sens;
    cps_ctrl_s ctrl;
    int n_mismatch = 0;
    int tests_run = 0;
    int cycles = 0;
    logic [31:0] seed = 32'h80B3;
    logic lf_rst = 1'b1;
    logic lf_done = 1'b0;
    cps_sens_s want_lf = '0;
    cps_sens_s sens_lf;
    cps_ctrl_s ctrl_lf;

    cps_top #(.SEC_CYCLES(SC)) u_dut (
        .CLK(clk),
        .SYS_RST(sys_rst),
        .SENS(sens),
        .CTRL(ctrl)
    );

    cps_plant_model u_plant (
        .clk(clk),
        .want(want),
        .running(ctrl.comp_run),
        .sens(sens)
    );

    // One cycle per second makes the long timers reachable
    cps_top #(.SEC_CYCLES(1)) u_dut_lf (
        .CLK(clk),
        .SYS_RST(lf_rst),
        .SENS(sens_lf),
        .CTRL(ctrl_lf)
    );

    cps_plant_model u_plant_lf (
        .clk(clk),
        .want(want_lf),
        .running(ctrl_lf.comp_run),
        .sens(sens_lf)
    );

    initial begin
        forever #2 clk = ~clk;
    end

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd

    task automatic tally_and_finish();
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : tally_and_finish

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("FAIL %0t seen %0h expected %0h", $time, seen, exp);
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : cyc

    task automatic wait_run(input logic lvl, input int max, output int n);
        n = 0;
        while (ctrl.comp_run !== lvl && n < max) begin
            @(posedge clk);
            n++;
        end
    endtask : wait_run

    // Off time is judged against tick phase, hence the small slack
    task automatic hold_is(input int secs);
        int n;
        wait_run(1'b1, secs * SC + 40, n);
        chk(n >= secs * SC - 15 && n <= secs * SC + 30, 1);
    endtask : hold_is

    task automatic trip(input int b);
        int n;
        want[b] <= 1'b1;
        wait_run(1'b0, 12, n);
        chk(ctrl.comp_run, 0);
        want[b] <= 1'b0;
    endtask : trip

    task automatic start(input cps_sens_s s);
        int n;
        sys_rst <= 1'b1;
        want <= s;
        cyc(16);
        chk(ctrl, 0);
        sys_rst <= 1'b0;
        wait_run(1'b1, 12, n);
        chk(ctrl.comp_run, 1);
    endtask : start

    task automatic fault_is(input cps_fault_e f, input logic cut);
        cyc(5);
        chk(ctrl.fault_code, f);
        chk(ctrl.timer_blink, 1);
        chk(ctrl.op_stop, 1);
        chk(ctrl.relay_cut, cut);
        cyc(200);
        chk(ctrl.comp_run, 0);
    endtask : fault_is

    always @(posedge clk) begin
        cycles++;
        if (cycles == 60000) begin
            n_mismatch++;
            $display("FAIL %0t run did not complete", $time);
            tally_and_finish();
        end
    end

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    initial begin
        int n;
        logic [5:0] r;
        start(20'hC0000);
        n = 0;
        while (ctrl.outair_reg_en !== 1'b1 && n < 700) begin
            cyc(1);
            n++;
        end
        chk(n >= 585 && n <= 625, 1);
        want[NORM_B] <= 1'b1;
        cyc(10);
        chk(ctrl.freq_down, 0);
        want[NORM_B] <= 1'b0;
        want[INIT_B] <= 1'b1;
        cyc(10);
        chk(ctrl.freq_down, 1);
        want[INIT_B] <= 1'b0;
        for (int m = 0; m < 2; m++) begin
            want[COOL_B] <= (m == 0);
            want[HEAT_B] <= (m == 1);
            for (int k = 0; k < 10; k++) begin
                r = (k == 0) ? 6'h3F : 6'(rnd());
                want[5:0] <= r;
                cyc(8);
                chk(ctrl.freq_lower, m ? &r[2:0] : &r[5:3]);
            end
        end
        want[5:0] <= 6'h00;
        want[NORM_B] <= 1'b1;
        cyc(10);
        chk(ctrl.freq_down, 1);
        chk(ctrl.freq_up_ok, 0);
        want[NORM_B] <= 1'b0;
        cyc(38);
        chk(ctrl.freq_up_ok, 0);
        cyc(40);
        chk(ctrl.freq_up_ok, 1);
        chk(ctrl.freq_down, 0);
        want[RUN_B] <= 1'b0;
        wait_run(1'b0, 12, n);
        want[RUN_B] <= 1'b1;
        hold_is(180);
        trip(HARD_B);
        hold_is(180);
        for (int i = 0; i < 4; i++) begin
            trip(DIS_B);
            if (i < 3) hold_is(180);
        end
        fault_is(CPS_FLT_DIS, 1'b0);
        start(20'h80000);
        for (int i = 0; i < 4; i++) begin
            trip(HOT_B);
            if (i == 0) begin
                cyc(2500);
                chk(ctrl.comp_run, 0);
            end
            if (i < 3) begin
                want[COOLED_B] <= 1'b1;
                hold_is(180);
                want[COOLED_B] <= 1'b0;
            end
        end
        fault_is(CPS_FLT_PSM, 1'b0);
        start(20'h80000);
        trip(DC_B);
        hold_is(180);
        cyc(10 + rnd() % 150);
        trip(DC_B);
        hold_is(120);
        cyc(400);
        trip(DC_B);
        hold_is(60);
        for (int i = 0; i < 7; i++) begin
            cyc(10 + rnd() % 150);
            trip(DC_B);
            if (i < 6) hold_is(120);
        end
        fault_is(CPS_FLT_DC, 1'b1);
        start(20'hC0300);
        wait_run(1'b0, 3100, n);
        chk(n >= 2985 && n <= 3035, 1);
        want[COOL_B] <= 1'b0;
        want[HEAT_B] <= 1'b1;
        want[DTC_B] <= 1'b0;
        want[DTH_B] <= 1'b1;
        hold_is(180);
        wait_run(1'b0, 3100, n);
        chk(n >= 2985 && n <= 3035, 1);
        fault_is(CPS_FLT_LEAK, 1'b0);
        while (!lf_done) begin
            cyc(1);
        end
        tally_and_finish();
    end

    // Cooling soft-limit switch-over and low-frequency forcing
    initial begin
        int n;
        want_lf <= 20'hC8040;
        cyc(16);
        lf_rst <= 1'b0;
        n = 0;
        while (ctrl_lf.comp_run !== 1'b1 && n < 12) begin
            cyc(1);
            n++;
        end
        chk(ctrl_lf.comp_run, 1);
        n = 0;
        while (ctrl_lf.freq_down !== 1'b1 && n < 2000) begin
            cyc(1);
            n++;
        end
        chk(n >= 1760 && n <= 1830, 1);
        while (ctrl_lf.force_23hz !== 1'b1 && n < 15000) begin
            cyc(1);
            n++;
        end
        chk(n >= 14360 && n <= 14430, 1);
        n = 0;
        while (ctrl_lf.force_23hz === 1'b1 && n < 200) begin
            cyc(1);
            n++;
        end
        chk(n, 120);
        lf_done = 1'b1;
    end

endmodule : tb_cps_top

`default_nettype wire
